// file: core/psh_cfg.svh
// Constants for the subsystem bus access handshake block
// Notes on behaviour
// - Output-enable fall ends access, clears latches
// - Read data driven only while output enable high
// - Qualify strobe validates latch, starts access request
// - Write sample one or two clocks, default two
// - Buffer enable from strobe, mapped only, ends
// - Hold request driven from clock rising edge
// - Grant already high means interlock unused
// - Acknowledge when memory or buffer transfer completes
// - Code zero buffered: advanced acknowledge when ready
// - Late advanced acknowledge waits for valid data
// - Negative acknowledge one clock, before acknowledge
// - Random fault marks window faulted, except four or in buffered mode
// - Missing interconnect address ignored: no request, no acknowledge, no negative acknowledge
// - Acknowledge only while enable flip-flop set
// - Memory override combinational, per window, chip select
// - Window zero override buffered: two clock delay
// - Delay code timing table without override
// - Override: codes one, two give two clocks
// - Interrupt pulse two clocks from rising edge
// - Address-latch fall latches address, direction, byte, select
`ifndef PSH_CFG_SVH
`define PSH_CFG_SVH
`define PSH_WIN_CNT       5
`define PSH_WIN_NO_FAULT  3'h4
`define PSH_WIN_OVR_ACK   3'h0
`define PSH_CODE_ADV      2'h0
`define PSH_CODE_FAST     2'h1
`define PSH_CODE_SLOW     2'h2
`define PSH_CODE_RST      2'h1
`define PSH_WDLY_INIT     2'h2
`define PSH_WDLY_FAST     2'h1
`define PSH_OVR_ACK_CLKS  2'h2
`define PSH_INT_CLKS      2'h2
`define PSH_OVR_RST       5'h00
`define PSH_PIN_ALE       0
`define PSH_PIN_QUAL      1
`define PSH_PIN_OE        2
`define PSH_PIN_GRANT     3
`define PSH_PIN_CS_N      4
`define PSH_PIN_DIR       5
`define PSH_PIN_UBE_N     6
`define PSH_PIN_CNT       7
`endif

// file: core/psh_pkg.sv
// Types for the subsystem bus access handshake block
`include "psh_cfg.svh"
package psh_pkg;
   typedef enum logic [1:0] {
      PSH_HOLD_IDLE = 2'b00,
      PSH_HOLD_WAIT = 2'b01,
      PSH_HOLD_QUAL = 2'b10,
      PSH_HOLD_OWN  = 2'b11
   } psh_hold_e;

   typedef struct packed {
      logic [`PSH_PIN_CNT-1:0] pin_s1;
      logic [`PSH_PIN_CNT-1:0] pin_s2;
      logic [`PSH_PIN_CNT-1:0] pin_d;
      logic [15:0]             ad_s1;
      logic [15:0]             ad_s2;
      logic [15:0]             addr;
      logic                    latched;
      logic                    dir_read;
      logic                    ube_n;
      logic                    cs_n;
      logic                    ack_en;
      logic                    active;
      logic [1:0]              elapsed;
      logic                    done;
      logic                    wrote;
      logic                    nak_done;
      logic                    ack_n;
      logic                    nak_n;
      logic                    den_n;
      logic [15:0]             rdata;
      logic [1:0]              wdelay;
      logic [1:0]              ack_code;
      logic [`PSH_WIN_CNT-1:0] ovr_en;
      logic [`PSH_WIN_CNT-1:0] faulted;
      psh_hold_e               hold;
      logic                    hold_cmd_d;
      logic [1:0]              int_cnt;
      logic [1:0]              fifo_cnt;
      logic [15:0]             fifo_b0;
      logic [15:0]             fifo_b1;
   } psh_state_s;
endpackage

// file: core/psh_bus_handshake.sv
// Slave handshake logic for the multiplexed subsystem bus
`timescale 1ns/10ps
`include "psh_cfg.svh"
module psh_bus_handshake
(
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   input  wire logic         i_clk_en,
   input  wire logic         i_addr_latch,
   input  wire logic         i_qualify,
   input  wire logic         i_output_enable,
   input  wire logic         i_hold_grant,
   input  wire logic         i_chip_select_n,
   input  wire logic         i_direction,
   input  wire logic         i_upper_byte_enable_n,
   input  wire logic [15:0]  i_ad,
   output logic      [15:0]  o_ad,
   output logic              o_ad_oe,
   output logic              o_buffer_drive_enable_n,
   output logic              o_transfer_ack_n,
   output logic              o_nak_n,
   output logic              o_memory_override,
   output logic              o_bus_hold_request,
   output logic              o_interrupt,
   output logic      [15:0]  o_bus_addr,
   input  wire logic         i_addr_match,
   input  wire logic [2:0]   i_addr_window,
   input  wire logic         i_buffered_mode,
   input  wire logic         i_buf_ready,
   output logic              o_req,
   output logic              o_req_write,
   output logic              o_req_upper_byte_n,
   input  wire logic         i_access_done,
   input  wire logic         i_access_fault,
   input  wire logic [15:0]  i_rdata,
   output logic              o_wdata_valid,
   output logic      [15:0]  o_wdata,
   input  wire logic         i_wdata_ready,
   input  wire logic         i_ack_code_load,
   input  wire logic [1:0]   i_ack_delay_code,
   input  wire logic         i_wdelay_load,
   input  wire logic         i_wdelay_one,
   input  wire logic         i_ovr_load,
   input  wire logic [4:0]   i_ovr_en,
   input  wire logic [4:0]   i_fault_clear,
   output logic      [4:0]   o_faulted,
   input  wire logic         i_hold_cmd,
   output logic              o_hold_granted,
   input  wire logic         i_int_request
);
   psh_pkg::psh_state_s r_reg;
   psh_pkg::psh_state_s r_next;

   logic       ale_rise;
   logic       ale_fall;
   logic       qual_rise;
   logic       oe_fall;
   logic       valid;
   logic       ovr_here;
   logic [1:0] need;
   logic       ack_go;
   logic       adv_early;
   logic       push;
   logic       pop;

   // Edges are taken from the second and third stages only
   assign ale_rise  = r_reg.pin_s2[`PSH_PIN_ALE] & ~r_reg.pin_d[`PSH_PIN_ALE];
   assign ale_fall  = ~r_reg.pin_s2[`PSH_PIN_ALE] & r_reg.pin_d[`PSH_PIN_ALE];
   assign qual_rise = r_reg.pin_s2[`PSH_PIN_QUAL]
                      & ~r_reg.pin_d[`PSH_PIN_QUAL];
   assign oe_fall   = ~r_reg.pin_s2[`PSH_PIN_OE] & r_reg.pin_d[`PSH_PIN_OE];

   // Faulted windows are ignored as if unmapped
   assign valid = r_reg.latched & ~r_reg.cs_n & i_addr_match
                  & ~r_reg.faulted[i_addr_window];
   assign ovr_here = r_reg.ovr_en[i_addr_window];

   // Address to the window matcher: live until latched, then held
   assign o_bus_addr = r_reg.latched ? r_reg.addr : r_reg.ad_s2;

   // Override is pure gating, so it tracks the address without a clock
   assign o_memory_override = i_addr_match & ovr_here
                              & ~(r_reg.latched ? r_reg.cs_n
                                  : r_reg.pin_s2[`PSH_PIN_CS_N]);

   // Least delay from the strobe rise, per delay code and override
   always_comb
   begin
      need = r_reg.dir_read ? 2'h0 : 2'h1;
      if (r_reg.ack_code == `PSH_CODE_SLOW)
      begin
         need = r_reg.dir_read ? 2'h1 : 2'h2;
      end
      if (ovr_here && r_reg.ack_code != `PSH_CODE_ADV)
      begin
         need = `PSH_OVR_ACK_CLKS;
      end
      if (ovr_here && i_buffered_mode
          && i_addr_window == `PSH_WIN_OVR_ACK
          && r_reg.ack_code != `PSH_CODE_ADV)
      begin
         need = `PSH_OVR_ACK_CLKS;
      end
      if (r_reg.ack_code == `PSH_CODE_ADV)
      begin
         need = 2'h0;
      end
   end

   // Advanced answer before the strobe needs a ready buffer
   assign adv_early = r_reg.ack_code == `PSH_CODE_ADV & i_buffered_mode
                      & i_buf_ready & ~r_reg.active;

   // Write path needs the word taken before the answer
   assign ack_go = r_reg.ack_en & valid & r_reg.ack_code != 2'h3
                   & (adv_early
                      | (r_reg.active & r_reg.done
                         & (r_reg.dir_read | r_reg.wrote)
                         & r_reg.elapsed >= need));

   assign push = r_reg.active & ~r_reg.dir_read & ~r_reg.wrote & valid
                 & r_reg.elapsed >= r_reg.wdelay
                 & r_reg.fifo_cnt != 2'h2;
   assign pop  = r_reg.fifo_cnt != 2'h0 & i_wdata_ready;

   always_comb
   begin
      r_next = r_reg;
      r_next.pin_s1 = {i_upper_byte_enable_n, i_direction, i_chip_select_n,
                       i_hold_grant, i_output_enable, i_qualify,
                       i_addr_latch};
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.pin_d  = r_reg.pin_s2;
      r_next.ad_s1  = i_ad;
      r_next.ad_s2  = r_reg.ad_s1;

      if (ale_rise)
      begin
         r_next.ack_en = 1'b1;
      end
      if (ale_fall)
      begin
         r_next.latched  = 1'b1;
         r_next.addr     = r_reg.ad_s2;
         r_next.dir_read = r_reg.pin_s2[`PSH_PIN_DIR];
         r_next.ube_n    = r_reg.pin_s2[`PSH_PIN_UBE_N];
         r_next.cs_n     = r_reg.pin_s2[`PSH_PIN_CS_N];
      end

      if (qual_rise && valid)
      begin
         r_next.active  = 1'b1;
         r_next.elapsed = 2'h0;
         r_next.den_n   = 1'b0;
      end
      else if (r_reg.active && r_reg.elapsed != 2'h3)
      begin
         r_next.elapsed = r_reg.elapsed + 2'h1;
      end

      // A completion in the strobe cycle itself must not be lost
      if ((r_reg.active || (qual_rise && valid)) && i_access_done)
      begin
         r_next.done = 1'b1;
         if (r_reg.dir_read)
         begin
            r_next.rdata = i_rdata;
         end
      end
      if (push)
      begin
         r_next.wrote = 1'b1;
      end

      // A fault answer spends one clock on the negative pulse first
      r_next.nak_n = 1'b1;
      if (ack_go && r_reg.ack_n)
      begin
         if (i_access_fault && !r_reg.nak_done)
         begin
            r_next.nak_n    = 1'b0;
            r_next.nak_done = 1'b1;
         end
         else
         begin
            r_next.ack_n = 1'b0;
            // Marked with the answer, so the faulted access still ends
            if (r_reg.nak_done && !i_buffered_mode
                && i_addr_window != `PSH_WIN_NO_FAULT)
            begin
               r_next.faulted[i_addr_window] = 1'b1;
            end
            if (!r_reg.dir_read)
            begin
               r_next.den_n = 1'b1;
            end
         end
      end
      if (!r_reg.ack_en)
      begin
         r_next.ack_n = 1'b1;
      end

      if (oe_fall)
      begin
         r_next.ack_en   = 1'b0;
         r_next.ack_n    = 1'b1;
         r_next.den_n    = 1'b1;
         r_next.latched  = 1'b0;
         r_next.cs_n     = 1'b1;
         r_next.dir_read = 1'b0;
         r_next.ube_n    = 1'b1;
         r_next.active   = 1'b0;
         r_next.done     = 1'b0;
         r_next.wrote    = 1'b0;
         r_next.nak_done = 1'b0;
      end

      // Clearing loses to a fault raised in the same clock
      r_next.faulted = r_next.faulted
                       & ~(i_fault_clear & ~(r_next.faulted & ~r_reg.faulted));

      if (i_ack_code_load)
      begin
         r_next.ack_code = i_ack_delay_code;
      end
      if (i_wdelay_load)
      begin
         r_next.wdelay = i_wdelay_one ? `PSH_WDLY_FAST : `PSH_WDLY_INIT;
      end
      if (i_ovr_load)
      begin
         r_next.ovr_en = i_ovr_en;
      end

      // Hold interlock
      r_next.hold_cmd_d = i_hold_cmd;
      case (r_reg.hold)
         psh_pkg::PSH_HOLD_IDLE:
         begin
            if (i_hold_cmd)
            begin
               if (r_reg.pin_s2[`PSH_PIN_GRANT])
               begin
                  r_next.hold = psh_pkg::PSH_HOLD_OWN;
               end
               else
               begin
                  r_next.hold = psh_pkg::PSH_HOLD_WAIT;
               end
            end
         end
         psh_pkg::PSH_HOLD_WAIT:
         begin
            if (!i_hold_cmd)
            begin
               r_next.hold = psh_pkg::PSH_HOLD_IDLE;
            end
            else if (r_reg.pin_s2[`PSH_PIN_GRANT])
            begin
               r_next.hold = psh_pkg::PSH_HOLD_QUAL;
            end
         end
         psh_pkg::PSH_HOLD_QUAL:
         begin
            if (!i_hold_cmd)
            begin
               r_next.hold = psh_pkg::PSH_HOLD_IDLE;
            end
            else if (qual_rise)
            begin
               r_next.hold = psh_pkg::PSH_HOLD_OWN;
            end
         end
         psh_pkg::PSH_HOLD_OWN:
         begin
            if (!i_hold_cmd)
            begin
               r_next.hold = psh_pkg::PSH_HOLD_IDLE;
            end
         end
         default:
         begin
            r_next.hold = psh_pkg::PSH_HOLD_IDLE;
         end
      endcase

      // Interrupt pulse; a new request restarts the count
      if (i_int_request)
      begin
         r_next.int_cnt = `PSH_INT_CLKS;
      end
      else if (r_reg.int_cnt != 2'h0)
      begin
         r_next.int_cnt = r_reg.int_cnt - 2'h1;
      end

      // Two-entry write buffer; entry 0 is the head
      if (pop)
      begin
         r_next.fifo_b0 = r_reg.fifo_b1;
      end
      if (push)
      begin
         if (r_reg.fifo_cnt == 2'h0 || (r_reg.fifo_cnt == 2'h1 && pop))
         begin
            r_next.fifo_b0 = r_reg.ad_s2;
         end
         else
         begin
            r_next.fifo_b1 = r_reg.ad_s2;
         end
      end
      if (push && !pop)
      begin
         r_next.fifo_cnt = r_reg.fifo_cnt + 2'h1;
      end
      else if (pop && !push)
      begin
         r_next.fifo_cnt = r_reg.fifo_cnt - 2'h1;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_resetn)
      begin
         r_reg <= '0;
         r_reg.pin_s1     <= 7'h50;
         r_reg.pin_s2     <= 7'h50;
         r_reg.pin_d      <= 7'h50;
         r_reg.cs_n       <= 1'b1;
         r_reg.ube_n      <= 1'b1;
         r_reg.ack_n      <= 1'b1;
         r_reg.nak_n      <= 1'b1;
         r_reg.den_n      <= 1'b1;
         r_reg.wdelay     <= `PSH_WDLY_INIT;
         r_reg.ack_code   <= `PSH_CODE_RST;
         r_reg.ovr_en     <= `PSH_OVR_RST;
         r_reg.hold       <= psh_pkg::PSH_HOLD_IDLE;
      end
      else if (i_clk_en)
      begin
         r_reg <= r_next;
      end
   end

   // Read data only while output enable is up on a live read
   assign o_ad    = r_reg.rdata;
   assign o_ad_oe = r_reg.active & r_reg.dir_read & r_reg.done
                    & r_reg.pin_s2[`PSH_PIN_OE];

   assign o_buffer_drive_enable_n = r_reg.den_n;
   assign o_transfer_ack_n        = r_reg.ack_n;
   assign o_nak_n                 = r_reg.nak_n;
   assign o_bus_hold_request      = r_reg.hold != psh_pkg::PSH_HOLD_IDLE;
   assign o_hold_granted          = r_reg.hold == psh_pkg::PSH_HOLD_OWN;
   assign o_interrupt             = r_reg.int_cnt != 2'h0;
   assign o_faulted               = r_reg.faulted;
   assign o_req                   = qual_rise & valid;
   assign o_req_write             = ~r_reg.dir_read;
   assign o_req_upper_byte_n      = r_reg.ube_n;
   assign o_wdata_valid           = r_reg.fifo_cnt != 2'h0;
   assign o_wdata                 = r_reg.fifo_b0;
endmodule

// file: tb/psh_bus_checker.sv
// Port assertions for the subsystem bus handshake block
`timescale 1ns/10ps
module psh_bus_checker
(
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_output_enable,
   input wire logic i_hold_cmd,
   input wire logic i_addr_match,
   input wire logic o_ad_oe,
   input wire logic o_buffer_drive_enable_n,
   input wire logic o_transfer_ack_n,
   input wire logic o_nak_n,
   input wire logic o_memory_override,
   input wire logic o_bus_hold_request,
   input wire logic o_interrupt,
   input wire logic o_req
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   property p_int_width;
      $rose(o_interrupt) |-> o_interrupt [*2] ##1 !o_interrupt;
   endproperty
   a_int_width: assert property (p_int_width)
      else $error("interrupt pulse width");
   property p_nak_pulse;
      $fell(o_nak_n) |=> o_nak_n && !o_transfer_ack_n;
   endproperty
   a_nak_pulse: assert property (p_nak_pulse)
      else $error("negative ack not one cycle before ack");
   property p_req_pulse;
      o_req |=> !o_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("access request longer than one cycle");
   property p_den_start;
      $fell(o_buffer_drive_enable_n) |-> $past(o_req);
   endproperty
   a_den_start: assert property (p_den_start)
      else $error("buffer enable without a started access");
   property p_drive_read;
      o_ad_oe |-> !o_buffer_drive_enable_n;
   endproperty
   a_drive_read: assert property (p_drive_read)
      else $error("data driven outside an access");
   property p_hold_req;
      $rose(i_hold_cmd) |=> o_bus_hold_request;
   endproperty
   a_hold_req: assert property (p_hold_req)
      else $error("hold request late");
   // Ack, once asserted, must stay asserted for the two clocks after it falls
   property p_ack_stands;
      $fell(o_transfer_ack_n) |=> !o_transfer_ack_n [*2];
   endproperty
   a_ack_stands: assert property (p_ack_stands)
      else $error("ack withdrawn early");
   property p_ack_end;
      $fell(i_output_enable) && !o_transfer_ack_n
         |-> ##[1:6] o_transfer_ack_n && o_buffer_drive_enable_n;
   endproperty
   a_ack_end: assert property (p_ack_end)
      else $error("access not ended by output enable fall");
   property p_ovr_match;
      o_memory_override |-> i_addr_match;
   endproperty
   a_ovr_match: assert property (p_ovr_match)
      else $error("override without mapped address");
endmodule
bind psh_bus_handshake psh_bus_checker psh_bus_checker_i
(
   .i_clk_sys(i_clk_sys),
   .i_resetn(i_resetn),
   .i_output_enable(i_output_enable),
   .i_hold_cmd(i_hold_cmd),
   .i_addr_match(i_addr_match),
   .o_ad_oe(o_ad_oe),
   .o_buffer_drive_enable_n(o_buffer_drive_enable_n),
   .o_transfer_ack_n(o_transfer_ack_n),
   .o_nak_n(o_nak_n),
   .o_memory_override(o_memory_override),
   .o_bus_hold_request(o_bus_hold_request),
   .o_interrupt(o_interrupt),
   .o_req(o_req)
);

// file: tb/psh_ps_master.sv
// Subsystem bus master model driving the block's pins
`timescale 1ns/10ps
module psh_ps_master
(
   input  wire logic        i_clk,
   input  wire logic        i_req,
   input  wire logic        i_ack_n,
   input  wire logic        i_ad_oe,
   input  wire logic [15:0] i_ad,
   output logic             o_ale,
   output logic             o_qual,
   output logic             o_oe,
   output logic             o_grant,
   output logic             o_cs_n,
   output logic             o_dir,
   output logic [15:0]      o_ad
);
   initial
   begin
      o_ale = 1'b0;
      o_qual = 1'b0;
      o_oe = 1'b0;
      o_grant = 1'b0;
      o_cs_n = 1'b1;
      o_dir = 1'b0;
      o_ad = 16'hA5A5;
   end
   // Pins move on falling edges only, so strobe rises land there
   task automatic acc(input logic rd, input logic cs_n,
                      input logic [15:0] d, output int lat,
                      output logic [15:0] q);
      int n;
      lat = -1;
      q = 16'hXXXX;
      n = 0;
      @(negedge i_clk);
      o_ad = 16'h1234;
      o_dir = rd;
      o_cs_n = cs_n;
      o_ale = 1'b1;
      repeat (4) @(negedge i_clk);
      o_ale = 1'b0;
      repeat (4) @(negedge i_clk);
      // Released bus shows the inverse so a stale value cannot pass
      o_ad = rd ? 16'hEDCB : d;
      o_qual = 1'b1;
      o_oe = 1'b1;
      while (!i_req && n < 8)
      begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      while (i_ack_n && n < 12)
      begin
         @(negedge i_clk);
         n++;
      end
      if (!i_ack_n)
      begin
         lat = n;
         q = i_ad_oe ? i_ad : 16'hXXXX;
      end
      repeat (2) @(negedge i_clk);
      o_oe = 1'b0;
      o_qual = 1'b0;
      o_ad = ~o_ad;
      o_cs_n = 1'b1;
      repeat (6) @(negedge i_clk);
   endtask
   // Grant may be asynchronous, hence the qualifying strobe after it
   task automatic grant_pulse();
      o_grant = 1'b1;
      repeat (3) @(negedge i_clk);
      o_grant = 1'b0;
      o_qual = 1'b1;
      repeat (3) @(negedge i_clk);
      o_qual = 1'b0;
      repeat (4) @(negedge i_clk);
   endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the subsystem bus handshake block
`timescale 1ns/10ps
module tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        match = 1'b1;
   logic [2:0]  win = 3'h1;
   logic        bufm = 1'b0;
   logic        brdy = 1'b1;
   logic        flt = 1'b0;
   logic        done = 1'b0;
   logic        wrdy = 1'b1;
   logic        cld = 1'b0;
   logic [1:0]  code = 2'h1;
   logic        wld = 1'b0;
   logic        old = 1'b0;
   logic [4:0]  ovr = 5'h00;
   logic [4:0]  fclr = 5'h00;
   logic        hcmd = 1'b0;
   logic        ireq = 1'b0;
   logic        ale, qual, oe, grant, csn, dir, ad_oe, den_n, ack_n;
   logic        nak_n, ovr_o, hreq, intr, req, wv, hgr, ovr_req;
   logic [15:0] ad_in, dout, wd, q;
   logic [4:0]  faulted;
   logic        rw_o, ube_o;
   logic [1:0]  kind_req;
   logic [15:0] baddr, addr_req;
   logic [15:0] wq[$];
   int          errors, n_checks, naks, ihi, cyc, lat;
   always #5 clk = ~clk;
   psh_ps_master psh_ps_master_i
   (
      .i_clk(clk), .i_req(req), .i_ack_n(ack_n), .i_ad_oe(ad_oe),
      .i_ad(dout), .o_ale(ale), .o_qual(qual), .o_oe(oe),
      .o_grant(grant), .o_cs_n(csn), .o_dir(dir), .o_ad(ad_in)
   );
   psh_bus_handshake psh_bus_handshake_i
   (
      .i_clk_sys(clk), .i_resetn(rstn), .i_clk_en(1'b1),
      .i_addr_latch(ale), .i_qualify(qual), .i_output_enable(oe),
      .i_hold_grant(grant), .i_chip_select_n(csn), .i_direction(dir),
      .i_upper_byte_enable_n(1'b0), .i_ad(ad_in), .o_ad(dout),
      .o_ad_oe(ad_oe), .o_buffer_drive_enable_n(den_n),
      .o_transfer_ack_n(ack_n), .o_nak_n(nak_n),
      .o_memory_override(ovr_o), .o_bus_hold_request(hreq),
      .o_interrupt(intr), .o_bus_addr(baddr), .i_addr_match(match),
      .i_addr_window(win), .i_buffered_mode(bufm), .i_buf_ready(brdy),
      .o_req(req), .o_req_write(rw_o), .o_req_upper_byte_n(ube_o),
      .i_access_done(done), .i_access_fault(flt), .i_rdata(16'hC3A5),
      .o_wdata_valid(wv), .o_wdata(wd), .i_wdata_ready(wrdy),
      .i_ack_code_load(cld), .i_ack_delay_code(code),
      .i_wdelay_load(wld), .i_wdelay_one(1'b1), .i_ovr_load(old),
      .i_ovr_en(ovr), .i_fault_clear(fclr), .o_faulted(faulted),
      .i_hold_cmd(hcmd), .o_hold_granted(hgr), .i_int_request(ireq)
   );
   // Internal side answers every request in its own cycle
   always @(negedge clk)
      done <= req;
   always @(posedge clk)
   begin
      if (wv && wrdy)
         wq.push_back(wd);
      if (!nak_n)
         naks++;
      if (intr)
         ihi++;
      if (req)
      begin
         ovr_req <= ovr_o;
         addr_req <= baddr;
         kind_req <= {rw_o, ube_o};
      end
      cyc++;
      if (cyc == 4000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [15:0] exp);
      psh_ps_master_i.acc(1'b1, 1'b0, 16'h0000, lat, q);
      chk(16'(lat), exp);
   endtask
   task automatic wr(input logic [15:0] d);
      psh_ps_master_i.acc(1'b0, 1'b0, d, lat, q);
   endtask
   task automatic pulse_ld(input logic [1:0] c, input logic [4:0] o);
      code = c;
      ovr = o;
      cld = 1'b1;
      old = 1'b1;
      @(negedge clk);
      cld = 1'b0;
      old = 1'b0;
   endtask
   initial
   begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk({ack_n, nak_n, den_n, hreq, intr, ad_oe, wv}, 7'h70);
      chk(faulted, 5'h00);
      rd(16'h0002);
      chk(q, 16'hC3A5);
      chk(ovr_req, 1'b0);
      chk(addr_req, 16'h1234);
      chk(16'(kind_req), 16'h0000);
      wr(16'h1357);
      chk(16'(lat >= 2), 16'h0001);
      chk(16'(kind_req), 16'h0002);
      chk(wq.size() ? wq.pop_front() : 16'hXXXX, 16'h1357);
      psh_ps_master_i.acc(1'b1, 1'b1, 16'h0000, lat, q);
      chk(16'(lat), 16'hFFFF);
      match = 1'b0;
      rd(16'hFFFF);
      match = 1'b1;
      pulse_ld(2'h2, 5'h00);
      rd(16'h0003);
      wr(16'h2468);
      chk(16'(lat >= 3), 16'h0001);
      chk(wq.size() ? wq.pop_front() : 16'hXXXX, 16'h2468);
      pulse_ld(2'h3, 5'h00);
      rd(16'hFFFF);
      // Override stays off while advanced mode is used, as advised
      win = 3'h0;
      bufm = 1'b1;
      pulse_ld(2'h1, 5'h01);
      rd(16'h0004);
      chk(ovr_req, 1'b1);
      pulse_ld(2'h2, 5'h01);
      rd(16'h0004);
      pulse_ld(2'h0, 5'h00);
      rd(16'h0000);
      brdy = 1'b0;
      rd(16'h0002);
      brdy = 1'b1;
      pulse_ld(2'h1, 5'h00);
      win = 3'h1;
      bufm = 1'b0;
      flt = 1'b1;
      naks = 0;
      psh_ps_master_i.acc(1'b1, 1'b0, 16'h0000, lat, q);
      chk(16'(lat > 0), 16'h0001);
      chk(16'(naks), 16'h0001);
      chk(faulted, 5'h02);
      flt = 1'b0;
      rd(16'hFFFF);
      fclr = 5'h02;
      @(negedge clk);
      fclr = 5'h00;
      win = 3'h4;
      flt = 1'b1;
      rd(16'h0003);
      chk(faulted, 5'h00);
      flt = 1'b0;
      win = 3'h1;
      // Receiver stalls: two words fit, the third is held off
      wld = 1'b1;
      @(negedge clk);
      wld = 1'b0;
      wrdy = 1'b0;
      wr(16'h1111);
      wr(16'h2222);
      wr(16'h3333);
      chk(16'(lat), 16'hFFFF);
      wrdy = 1'b1;
      repeat (4) @(negedge clk);
      chk(wq.size() ? wq.pop_front() : 16'hXXXX, 16'h1111);
      chk(wq.size() ? wq.pop_front() : 16'hXXXX, 16'h2222);
      ihi = 0;
      ireq = 1'b1;
      @(negedge clk);
      ireq = 1'b0;
      repeat (6) @(negedge clk);
      chk(16'(ihi), 16'h0002);
      hcmd = 1'b1;
      repeat (3) @(negedge clk);
      chk({hreq, hgr}, 2'b10);
      psh_ps_master_i.grant_pulse();
      chk(hgr, 1'b1);
      hcmd = 1'b0;
      psh_ps_master_i.o_grant = 1'b1;
      repeat (5) @(negedge clk);
      chk(hreq, 1'b0);
      hcmd = 1'b1;
      repeat (5) @(negedge clk);
      chk({hreq, hgr}, 2'b11);
      stop_test();
   end
endmodule
